// *** verilog/io_ctl_defs.svh ***
// Constants for the bus command-cycle control: field positions, codes, register map.
// Assumes inclusion by bare name from package and design modules alike.
`ifndef IO_CTL_DEFS_SVH
`define IO_CTL_DEFS_SVH

// Bus field layout
`define BUS_W 24
`define BASIC_HI 23
`define BASIC_LO 20
`define CHAN_HI 19
`define CHAN_LO 16
`define SUB_HI 3
`define SUB_LO 0
`define STAT_HI 20
`define STAT_LO 16
`define READ_REV_BIT 21
`define DATA_HI 15
`define DATA_LO 0
`define ID_HI 6
`define ID_LO 1

// Basic commands and sub-commands
`define BASIC_INPUT 4'h4
`define BASIC_VARIANT 4'h1
`define SUB_TEST 4'h1
`define SUB_CLEAR_TEST 4'h3
`define SUB_POLL 4'h5
`define SUB_TERMINATE 4'h6

// Register indices on the software port
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_DATA 4'h2
`define REG_ID 4'h3
`define REG_TERM_STATUS 4'h4
`define REG_IRQ_STATUS 4'h5
`define REG_IRQ_CLEAR 4'h6
`define REG_IRQ_ENABLE 4'h7

// Control register fields
`define CTRL_CHAN_HI 3
`define CTRL_CHAN_LO 0
`define CTRL_ENABLE 4
`define CTRL_READ_REV 5
`define CTRL_SVC_REQ 6

// Event bits
`define EV_INPUT 0
`define EV_TEST 1
`define EV_CLEAR 2
`define EV_TERMINATE 3
`define EV_POLL 4
`define EV_W 5

// Reset values
`define CTRL_RST 7'h00
`define STATUS_RST 5'h00
`define DATA_RST 16'h0000
`define ID_DEFAULT 6'h2A

`endif

// *** verilog/io_ctl_pkg.sv ***
// Types shared by the bus command-cycle control modules.
// Assumes io_ctl_defs.svh is on the include path.
`include "io_ctl_defs.svh"

package io_ctl_pkg;

  // Decoded first-phase command
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_INPUT,
    CMD_TEST,
    CMD_CLEAR_TEST,
    CMD_POLL,
    CMD_TERMINATE
  } cmd_kind_t;

  // Cycle sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LATCHED,
    ST_DRIVE,
    ST_SINK,
    ST_WAIT_END
  } cyc_state_t;

  typedef logic [`BUS_W-1:0] bus_word_t;

endpackage : io_ctl_pkg

// *** verilog/cmd_if.sv ***
// Carrier between sequencer and command decoder.
// Assumes io_ctl_pkg compiled first.
`timescale 1ns/10ps

interface cmd_if;
  import io_ctl_pkg::*;
  bus_word_t word; // Latched first-phase word
  logic [3:0] own_channel; // Configured channel number
  cmd_kind_t kind; // Decoded command
  logic addressed; // Command concerns this control

  modport seq (output word, output own_channel, input kind, input addressed);
  modport dec (input word, input own_channel, output kind, output addressed);
endinterface : cmd_if

// *** verilog/pin_sync.sv ***
// Two-stage synchroniser for a group of pin inputs.
// Assumes pins are asynchronous to clk; only stage two is read outside.
`timescale 1ns/10ps

module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import io_ctl_pkg::*;

  // Both stages held as one state record
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t st_r; // Registered stages
  sync_state_t st_nxt; // Next stages

  // Shift pins through two stages
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  // Synchronous reset to zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule : pin_sync

// *** verilog/cmd_decoder.sv ***
// Decodes the first-phase word into a command kind and an address match.
// Assumes a stable latched word from the sequencer.
`timescale 1ns/10ps

`include "io_ctl_defs.svh"

module cmd_decoder (
  cmd_if.dec cif
);
  import io_ctl_pkg::*;

  // Classify command and check channel field
  always_comb begin
    cif.kind = CMD_NONE;
    cif.addressed = 1'b0;
    if (cif.word[`BASIC_HI:`BASIC_LO] == `BASIC_INPUT) begin
      cif.kind = CMD_INPUT;
    end else if (cif.word[`BASIC_HI:`BASIC_LO] == `BASIC_VARIANT) begin
      // Sub-command picks the cycle type
      case (cif.word[`SUB_HI:`SUB_LO])
        `SUB_TEST: cif.kind = CMD_TEST;
        `SUB_CLEAR_TEST: cif.kind = CMD_CLEAR_TEST;
        `SUB_POLL: cif.kind = CMD_POLL;
        `SUB_TERMINATE: cif.kind = CMD_TERMINATE;
        default: cif.kind = CMD_NONE;
      endcase
    end
    // Poll concerns all controls; others need channel match
    if (cif.kind == CMD_POLL) begin
      cif.addressed = 1'b1;
    end else if (cif.kind != CMD_NONE) begin
      cif.addressed = (cif.word[`CHAN_HI:`CHAN_LO] == cif.own_channel);
    end
  end

endmodule : cmd_decoder

// *** verilog/io_ctl.sv ***
// I/O control end of the shared 24-bit command bus.
// Assumes bus pins, phase signals and release strobe are asynchronous to clk;
// the bus wire level is resolved outside from bus_out and bus_oe.
//
// Summary of operation
// - Input-transfer basic command is 0100
// - Input transfer carries target channel below command
// - Input transfer returns sixteen data, five status
// - Release strobe makes responder free the bus
// - Test status: basic 0001, sub 0001
// - Basic 0001 means decode low sub-command
// - Variant cycles: channel in 19..16
// - Test status returns status and identification
// - Clear-and-test: basic 0001, sub 0011
// - Clear-and-test answers, then resets control
// - Service poll: sub 0101, no channel
// - Terminate data: sub 0110, channel addressed
// - Terminate marks end of current record
// - Basic command sits in bits 23..20
// - Bit 21 flags read-reverse with status
//
// Software register map, one index per register:
//   0 control: channel 3..0, enable 4, read-reverse 5, service request 6
//   1 status count, five bits, returned in every status answer
//   2 input data, sixteen bits, returned by an input transfer
//   3 identification, read only, from the parameter
//   4 status last sent by the processor in a terminate cycle, read only
//   5 event status, read only; 6 event clear, write only; 7 event enable
// Event bits: 0 input done, 1 test done, 2 clear done, 3 terminate, 4 poll.
//
// Hazards: every bus and phase pin passes two flops, so the processor must allow about
// three cycles after raising phase B before it samples the answer.
// A response ends on the release strobe or, failing that, when phase B drops.
`timescale 1ns/10ps

`include "io_ctl_defs.svh"

module io_ctl #(
  parameter logic [5:0] CONTROL_ID = `ID_DEFAULT // Arbitrary identification value
) (
  // Clock and synchronous reset
  input wire logic clk, // 100 MHz system clock
  input wire logic rst_n, // Active low, sampled on clk
  // Bus pins; the wire level is resolved outside
  input wire io_ctl_pkg::bus_word_t bus_in, // Bus level at the pins
  output io_ctl_pkg::bus_word_t bus_out, // Value this control drives
  output io_ctl_pkg::bus_word_t bus_oe, // Per-bit drive enable
  // Phase pins from the processor, asynchronous
  input wire logic command_phase_strobe, // First phase present
  input wire logic phase_b_indicator, // Second phase present
  input wire logic bus_release_strobe, // Free the bus
  // Software register port, same clock
  input wire logic [3:0] reg_addr, // Register index
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // One-cycle write strobe
  input wire logic reg_rd, // One-cycle read strobe
  output logic [31:0] reg_rdata, // Read data, one cycle after strobe
  // Interrupt to software
  output logic irq // High while an enabled event is set
);
  import io_ctl_pkg::*;

  // Whole state of the control
  typedef struct packed {
    // Cycle tracking
    cyc_state_t state; // Sequencer state
    bus_word_t cmd_word; // First-phase word as latched
    cmd_kind_t kind; // Command of the current cycle
    // Software-visible registers
    logic [6:0] ctrl; // Channel, enable, read-reverse, service request
    logic [4:0] status; // Status count
    logic [15:0] data; // Input transfer data
    logic [4:0] term_status; // Status from the last terminate
    // Interrupt state
    logic [`EV_W-1:0] irq_status; // Sticky events
    logic [`EV_W-1:0] irq_enable; // Events that may interrupt
    // Registered outputs
    bus_word_t out; // Drive value
    bus_word_t oe; // Drive enable
    logic [31:0] rdata; // Read data
    logic irq; // Interrupt line
  } ctl_state_t;

  // Single registered record and its next value
  ctl_state_t st_r; // Registered state
  ctl_state_t st_nxt; // Next state

  // Pin views after the two-flop synchroniser
  bus_word_t bus_s; // Synchronised bus
  logic [2:0] ctl_s; // Synchronised phase and strobe pins
  logic phase_a; // First phase active
  logic phase_b; // Second phase active
  logic release_s; // Release strobe seen

  // Carrier to the command decoder
  cmd_if cif ();

  // Bus and control pins through two flops
  pin_sync #(.W(`BUS_W + 3)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({bus_in, command_phase_strobe, phase_b_indicator, bus_release_strobe}),
    .q({bus_s, ctl_s})
  );

  // Name the synchronised control pins, in concatenation order
  assign phase_a = ctl_s[2];
  assign phase_b = ctl_s[1];
  assign release_s = ctl_s[0];

  // Decoder sees the latched command and own channel
  assign cif.word = st_r.cmd_word;
  assign cif.own_channel = st_r.ctrl[`CTRL_CHAN_HI:`CTRL_CHAN_LO];

  cmd_decoder u_dec (
    .cif(cif)
  );

  // Build the answer word for a status-returning cycle
  // Bits 23..22 stay zero: the top two bits of the command field are never driven
  function automatic bus_word_t status_word(input logic [4:0] stat, input logic rrev,
                                            input logic [15:0] low);
    bus_word_t w;
    w = '0;
    w[`STAT_HI:`STAT_LO] = stat;
    w[`READ_REV_BIT] = rrev;
    w[`DATA_HI:`DATA_LO] = low;
    return w;
  endfunction : status_word

  // Lanes owned by the status-returning answer
  // Poll answers build their own single-lane enable instead
  function automatic bus_word_t status_lanes(input logic [15:0] low);
    bus_word_t w;
    w = '0;
    w[`STAT_HI:`STAT_LO] = 5'h1F;
    w[`READ_REV_BIT] = 1'b1;
    w[`DATA_HI:`DATA_LO] = low;
    return w;
  endfunction : status_lanes

  // Sequencer, registers and interrupt in one pass
  always_comb begin
    logic [`EV_W-1:0] ev; // One-cycle event pulses
    logic [15:0] id_low; // Identification placed in the low lanes
    logic [`EV_W-1:0] clr; // Clear mask from software
    // Locals start clean on every pass
    ev = '0;
    clr = '0;
    id_low = '0;
    id_low[`ID_HI:`ID_LO] = CONTROL_ID;
    // Every field holds unless a branch below changes it
    st_nxt = st_r;

    // Cycle sequencer
    case (st_r.state)
      // Wait for a first phase; capture its word
      ST_IDLE: begin
        // A disabled control ignores the bus entirely
        if (phase_a && st_r.ctrl[`CTRL_ENABLE]) begin
          st_nxt.cmd_word = bus_s;
          st_nxt.state = ST_LATCHED;
        end
      end

      // Decode, then act once second phase opens
      ST_LATCHED: begin
        // Kind kept for the event and the clear at the end
        st_nxt.kind = cif.kind;
        if (phase_b) begin
          // Unaddressed or unknown commands sit out the phase
          st_nxt.state = ST_WAIT_END;
          if (cif.addressed) begin
            // Pick the answer for this cycle type
            case (cif.kind)
              // Data and status back to processor
              CMD_INPUT: begin
                // Status, read-reverse and all sixteen data lanes
                st_nxt.out = status_word(st_r.status, st_r.ctrl[`CTRL_READ_REV],
                                         st_r.data);
                st_nxt.oe = status_lanes(16'hFFFF);
                st_nxt.state = ST_DRIVE;
              end

              // Status and identification
              CMD_TEST, CMD_CLEAR_TEST: begin
                // Identification occupies lanes 6..1 only
                st_nxt.out = status_word(st_r.status, st_r.ctrl[`CTRL_READ_REV],
                                         id_low);
                st_nxt.oe = status_lanes(16'h007E);
                st_nxt.state = ST_DRIVE;
              end

              // Only a requesting control drives its own bit
              CMD_POLL: begin
                // No request pending: stay off the bus
                if (st_r.ctrl[`CTRL_SVC_REQ]) begin
                  // Clear every lane, then set the channel's own bit
                  st_nxt.out = '0;
                  st_nxt.oe = '0;
                  st_nxt.out[st_r.ctrl[`CTRL_CHAN_HI:`CTRL_CHAN_LO]] = 1'b1;
                  st_nxt.oe[st_r.ctrl[`CTRL_CHAN_HI:`CTRL_CHAN_LO]] = 1'b1;
                  st_nxt.state = ST_DRIVE;
                end
              end

              // Processor drives status to us
              CMD_TERMINATE: st_nxt.state = ST_SINK;
              default: st_nxt.state = ST_WAIT_END;
            endcase
          end
        end
      end

      // Hold the answer until release strobe
      ST_DRIVE: begin
        // A lost phase B also ends the answer, so the bus is never held
        if (release_s || !phase_b) begin
          st_nxt.oe = '0;
          st_nxt.out = '0;
          st_nxt.state = ST_WAIT_END;
          // Record which answer completed; clear reports at phase end
          case (st_r.kind)
            CMD_INPUT: ev[`EV_INPUT] = 1'b1;
            CMD_TEST: ev[`EV_TEST] = 1'b1;
            CMD_POLL: ev[`EV_POLL] = 1'b1;
            default: ev = '0;
          endcase
        end
      end

      // Capture processor status at release
      ST_SINK: begin
        // Processor status still stands on the synchronised bus here
        if (release_s || !phase_b) begin
          st_nxt.term_status = bus_s[`STAT_HI:`STAT_LO];
          ev[`EV_TERMINATE] = 1'b1;
          st_nxt.state = ST_WAIT_END;
        end
      end

      // Wait out second phase; clear command resets here
      ST_WAIT_END: begin
        // Both phase pins low means the cycle is over
        if (!phase_b && !phase_a) begin
          st_nxt.state = ST_IDLE;
          // Channel and enable survive the clear
          if (st_r.kind == CMD_CLEAR_TEST && cif.addressed) begin
            st_nxt.status = `STATUS_RST;
            st_nxt.data = `DATA_RST;
            st_nxt.ctrl[`CTRL_SVC_REQ] = 1'b0;
            st_nxt.ctrl[`CTRL_READ_REV] = 1'b0;
            ev[`EV_CLEAR] = 1'b1;
          end
          st_nxt.kind = CMD_NONE;
        end
      end

      // Unused encodings recover to idle
      default: st_nxt.state = ST_IDLE;
    endcase

    // Register writes; software wins over a clear in the same cycle
    if (reg_wr) begin
      if (reg_addr == `REG_CTRL) begin
        // Channel, enable, read-reverse, service request
        st_nxt.ctrl = reg_wdata[6:0];
      end else if (reg_addr == `REG_STATUS) begin
        // Status count returned in every status answer
        st_nxt.status = reg_wdata[4:0];
      end else if (reg_addr == `REG_DATA) begin
        // Data for the next input transfer
        st_nxt.data = reg_wdata[15:0];
      end else if (reg_addr == `REG_IRQ_CLEAR) begin
        // Ones clear event bits; nothing is stored
        clr = reg_wdata[`EV_W-1:0];
      end else if (reg_addr == `REG_IRQ_ENABLE) begin
        // Events allowed onto the interrupt
        st_nxt.irq_enable = reg_wdata[`EV_W-1:0];
      end
      // Other indices are read only or unmapped: ignored
    end

    // Sticky events; a new event beats a clear
    // Interrupt follows the next-state bits, so it leaves a flop
    st_nxt.irq_status = (st_r.irq_status & ~clr) | ev;
    st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_enable);

    // Register reads, data valid next cycle
    // Read data fall back to zero after one cycle
    st_nxt.rdata = '0;
    if (reg_rd) begin
      // Unmapped and write-only indices read zero
      if (reg_addr == `REG_CTRL) begin
        st_nxt.rdata = {25'h0000000, st_r.ctrl};
      end else if (reg_addr == `REG_STATUS) begin
        st_nxt.rdata = {27'h0000000, st_r.status};
      end else if (reg_addr == `REG_DATA) begin
        st_nxt.rdata = {16'h0000, st_r.data};
      end else if (reg_addr == `REG_ID) begin
        st_nxt.rdata = {26'h0000000, CONTROL_ID};
      end else if (reg_addr == `REG_TERM_STATUS) begin
        st_nxt.rdata = {27'h0000000, st_r.term_status};
      end else if (reg_addr == `REG_IRQ_STATUS) begin
        st_nxt.rdata = {27'h0000000, st_r.irq_status};
      end else if (reg_addr == `REG_IRQ_ENABLE) begin
        st_nxt.rdata = {27'h0000000, st_r.irq_enable};
      end
    end
  end

  // Synchronous reset of all state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Control comes up disabled and off the bus
      st_r.state <= ST_IDLE;
      st_r.cmd_word <= '0;
      st_r.kind <= CMD_NONE;
      st_r.ctrl <= `CTRL_RST;
      st_r.status <= `STATUS_RST;
      st_r.data <= `DATA_RST;
      st_r.term_status <= 5'h00;
      st_r.irq_status <= '0;
      st_r.irq_enable <= '0;
      st_r.out <= '0;
      st_r.oe <= '0;
      st_r.rdata <= 32'h00000000;
      st_r.irq <= 1'b0;
    end else begin
      // Whole record advances on every edge
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  // No logic between these flops and the pins
  assign bus_out = st_r.out;
  assign bus_oe = st_r.oe;
  assign reg_rdata = st_r.rdata;
  assign irq = st_r.irq;

endmodule : io_ctl

// *** test/io_ctl_properties.sv ***
// Checker for io_ctl: bus drive timing, poll shape, register read port.
// Assumes binding onto io_ctl; bus wire resolved outside the control.
`timescale 1ns/10ps

module io_ctl_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire io_ctl_pkg::bus_word_t bus_in,
  input wire io_ctl_pkg::bus_word_t bus_oe,
  input wire logic command_phase_strobe,
  input wire logic phase_b_indicator,
  input wire logic bus_release_strobe,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic irq
);
  import io_ctl_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Poll command seen for three cycles of phase A
  sequence poll_cmd;
    (command_phase_strobe && bus_in[23:20] == 4'h1 && bus_in[3:0] == 4'h5) [*3];
  endsequence
  // Poll answer: at most one low bit for eight cycles
  sequence poll_answer;
    (bus_oe[23:16] == 8'h0 && $onehot0(bus_oe)) [*8];
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read answer");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> bus_oe == 24'h0 && !irq)
    else $error("outputs active after reset");
  a_drive_after_phb: assert property ($rose(bus_oe != 24'h0) |-> $past(phase_b_indicator, 3))
    else $error("bus driven before phase B seen");
  a_drive_in_phb: assert property (bus_oe != 24'h0 |-> $past(phase_b_indicator) ||
    $past(phase_b_indicator, 2) || $past(phase_b_indicator, 4))
    else $error("bus driven outside phase B");
  a_release_frees: assert property ($rose(bus_release_strobe) |-> ##[1:5] bus_oe == 24'h0)
    else $error("bus still driven after release");
  a_stays_off: assert property ($fell(bus_oe != 24'h0) |-> (bus_oe == 24'h0) [*3])
    else $error("bus driven again after release");
  a_poll_one_bit: assert property (poll_cmd |-> poll_answer)
    else $error("poll answer not a single low bit");
  a_top_undriven: assert property (bus_oe[23:22] == 2'h0)
    else $error("command field driven by control");
endmodule : io_ctl_props

bind io_ctl io_ctl_props u_props (.clk, .rst_n, .bus_in, .bus_oe, .command_phase_strobe,
  .phase_b_indicator, .bus_release_strobe, .reg_rd, .reg_rdata, .irq);

// *** test/cpu_model.sv ***
// Processor end of the command bus: phase A word, phase B, release strobe.
// Assumes bench clock; bench resolves the wired bus from word and drv.
`timescale 1ns/10ps

module cpu_model (
  input wire logic clk,
  input wire io_ctl_pkg::bus_word_t bus_wire,
  output io_ctl_pkg::bus_word_t word,
  output logic drv,
  output logic cmd_stb,
  output logic phb,
  output logic rel
);
  import io_ctl_pkg::*;
  // Idle: nothing driven
  initial begin
    word = 24'h0;
    drv = 1'b0;
    cmd_stb = 1'b0;
    phb = 1'b0;
    rel = 1'b0;
  end
  // One command cycle; wait_n sets cycles from raising phase B to sampling the bus and raising release
  task run(input bus_word_t cmd, input bus_word_t st, input int wait_n,
           output bus_word_t rsp);
    logic term;
    term = cmd[23:20] == 4'h1 && cmd[3:0] == 4'h6;
    @(posedge clk);
    word <= cmd;
    drv <= 1'b1;
    cmd_stb <= 1'b1;
    repeat (4) @(posedge clk);
    cmd_stb <= 1'b0;
    drv <= term;
    word <= st;
    phb <= 1'b1;
    repeat (wait_n) @(posedge clk);
    rsp = bus_wire;
    rel <= 1'b1;
    repeat (2) @(posedge clk);
    phb <= 1'b0;
    rel <= 1'b0;
    drv <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : run
endmodule : cpu_model

// *** test/io_ctl_bench.sv ***
// Self-checking bench for io_ctl: register port and command cycles.
// Assumes cpu_model and io_ctl_props compiled first.
`timescale 1ns/10ps

module io_ctl_bench;
  import io_ctl_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, irq, drv, cmd_stb, phb, rel;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  bus_word_t bus_in, bus_out, bus_oe, word;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  // Resolved bus: processor word while drv, else the control's driven bits; undriven bits read low
  assign bus_in = drv ? word : (bus_out & bus_oe);
  io_ctl DUT (.clk(clk), .rst_n(rst_n), .bus_in(bus_in), .bus_out(bus_out),
    .bus_oe(bus_oe), .command_phase_strobe(cmd_stb), .phase_b_indicator(phb),
    .bus_release_strobe(rel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  cpu_model cpu (.clk(clk), .bus_wire(bus_in), .word(word), .drv(drv),
    .cmd_stb(cmd_stb), .phb(phb), .rel(rel));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Verdict and end of run
  task results();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      results();
    end
  end
  task chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk32
  task chk24(input bus_word_t got, input bus_word_t exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk24
  task wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  // Read; data stand in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk32(reg_rdata, exp);
    @(posedge clk);
  endtask : rd
  task cyc(input bus_word_t c, input bus_word_t st, input int w, input bus_word_t exp);
    bus_word_t r;
    cpu.run(c, st, w, r);
    chk24(r, exp);
  endtask : cyc
  // Main sequence
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 9; i++) rd(i[3:0], i == 3 ? 32'h2A : 32'h0);
    wr(4'h3, 32'h15);
    rd(4'h3, 32'h2A);
    wr(4'h0, 32'h13);
    wr(4'h1, 32'h0A);
    wr(4'h2, 32'hBEEF);
    wr(4'h7, 32'h1);
    rd(4'h2, 32'hBEEF);
    cyc(24'h430000, 24'h0, 6, 24'h0ABEEF);
    rd(4'h5, 32'h1);
    chk32({31'h0, irq}, 32'h1);
    wr(4'h6, 32'h1);
    rd(4'h5, 32'h0);
    chk32({31'h0, irq}, 32'h0);
    cyc(24'h450000, 24'h0, 20, 24'h0);
    wr(4'h0, 32'h73);
    cyc(24'h13ABC1, 24'h0, 6, 24'h2A0054);
    cyc(24'h1FABC5, 24'h0, 6, 24'h000008);
    cyc(24'h130002, 24'h0, 6, 24'h0);
    cyc(24'h130006, 24'h150000, 6, 24'h150000);
    rd(4'h4, 32'h15);
    cyc(24'h130003, 24'h0, 20, 24'h2A0054);
    rd(4'h0, 32'h13);
    rd(4'h1, 32'h0);
    rd(4'h2, 32'h0);
    rd(4'h5, 32'h1E);
    chk32({31'h0, irq}, 32'h0);
    wr(4'h7, 32'h1F);
    chk32({31'h0, irq}, 32'h1);
    wr(4'h6, 32'h1F);
    rd(4'h5, 32'h0);
    chk32({31'h0, irq}, 32'h0);
    results();
  end
endmodule : io_ctl_bench
